/* File: mcd_msi_cap.sv */
// Purpose: message signaled interrupt capability of a switch downstream port
// Assumes: dword configuration accesses with byte enables, single clock
// Notes: the write toward the host is a valid/ready channel
//        dword 70h carries control in bits 31:16, 74h and 78h the address,
//        7ch the payload in bits 15:0 and 80h the capability tag in bits 7:0
`timescale 1ns/100ps
`include "mcd_defs.svh"

module mcd_msi_cap
    import mcd_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_hit,
    input wire logic irq_event,
    input wire logic wr_ready,
    output logic wr_valid,
    output logic wr_wide,
    output logic [63:0] wr_addr,
    output logic [31:0] wr_data
);
    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [2:0] granted_message_count_q;
    logic message_interrupt_enable_q;
    logic [31:0] addr_lo_q;
    logic [31:0] addr_hi_q;
    logic [15:0] payload_q;
    logic [31:0] rdata_q;

    // reset image of the control word; fields are taken from it by position
    localparam logic [15:0] CTRL_RST = `MCD_CTRL_RESET;
    // hardwired control fields: the wide bit keeps its reset value, one message only
    localparam logic wide_address_capable = CTRL_RST[`MCD_CTRL_WIDE_BIT];
    localparam logic [2:0] supported_message_count = `MCD_SUPPORTED_CNT;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // keeps the old byte wherever its enable is low
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : be_merge

    // matches the dword part of an access address against a byte offset
    function automatic logic dw_hit(input logic [7:0] addr, input logic [7:0] off);
        return addr[7:2] == off[7:2];
    endfunction : dw_hit

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire logic sel_ctrl = dw_hit(cfg_addr, `MCD_OFF_CTRL_DW);
    wire logic sel_lo = dw_hit(cfg_addr, `MCD_OFF_ADDR_LO);
    wire logic sel_hi = dw_hit(cfg_addr, `MCD_OFF_ADDR_HI);
    wire logic sel_pl = dw_hit(cfg_addr, `MCD_OFF_PAYLOAD);
    wire logic sel_tag = dw_hit(cfg_addr, `MCD_OFF_CAPTAG_DW);
    wire logic any_sel = sel_ctrl | sel_lo | sel_hi | sel_pl | sel_tag;

    // per-register write strobes; the tag dword has none, so writes to it fall away
    wire logic we_ctrl = cfg_wr && sel_ctrl;
    wire logic we_lo = cfg_wr && sel_lo;
    wire logic we_hi = cfg_wr && sel_hi;
    wire logic we_pl = cfg_wr && sel_pl;

    // ----------------------------------------
    // field assembly
    // ----------------------------------------
    // control word: reserved high byte zero, wide bit one, granted and supported count fields, enable
    wire logic [15:0] ctrl_word = {`MCD_ZERO8,
                                   wide_address_capable,
                                   granted_message_count_q,
                                   supported_message_count,
                                   message_interrupt_enable_q};
    // the dword at 70h carries control in its upper half at 72h
    wire logic [31:0] ctrl_dw = {ctrl_word, `MCD_ZERO16};
    // payload fields travel to the sender as programmed
    wire logic [11:0] fixed_payload_bits = payload_q[`MCD_PL_FIX_HI:`MCD_PL_FIX_LO];
    wire logic [3:0] message_index_bits = payload_q[`MCD_PL_IDX_HI:`MCD_PL_IDX_LO];

    // ----------------------------------------
    // write data
    // ----------------------------------------
    wire logic [31:0] ctrl_merged = be_merge(ctrl_dw, cfg_wdata, cfg_be);
    wire logic [31:0] lo_merged = be_merge(addr_lo_q, cfg_wdata, cfg_be);
    wire logic [31:0] hi_merged = be_merge(addr_hi_q, cfg_wdata, cfg_be);
    wire logic [31:0] pl_merged = be_merge({`MCD_ZERO16, payload_q}, cfg_wdata, cfg_be);
    // values a write leaves behind, read-only bits dropped
    wire logic [2:0] granted_message_count_d = ctrl_merged[`MCD_CTRL_SHIFT+`MCD_CTRL_CNT_HI:
        `MCD_CTRL_SHIFT+`MCD_CTRL_CNT_LO];
    wire logic message_interrupt_enable_d = ctrl_merged[`MCD_CTRL_SHIFT+`MCD_CTRL_EN_BIT];
    wire logic [31:0] addr_lo_d = lo_merged & `MCD_ADDR_LO_MASK;
    wire logic [31:0] addr_hi_d = hi_merged;
    wire logic [15:0] payload_d = pl_merged[`MCD_PL_FIX_HI:`MCD_PL_IDX_LO];

    // ----------------------------------------
    // read data
    // ----------------------------------------
    wire logic [31:0] rd_lo = addr_lo_q & `MCD_ADDR_LO_MASK;
    wire logic [31:0] rd_pl = {`MCD_ZERO16, payload_q};
    wire logic [31:0] rd_tag = {`MCD_ZERO24, `MCD_CAP_TAG};
    // unmapped dwords read zero
    wire logic [31:0] rd_mux =
        sel_ctrl ? ctrl_dw :
        sel_lo ? rd_lo :
        sel_hi ? addr_hi_q :
        sel_pl ? rd_pl :
        sel_tag ? rd_tag :
        `MCD_ZERO32;

    // ----------------------------------------
    // control fields
    // ----------------------------------------
    // reserved count codes are stored as written
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            granted_message_count_q <= CTRL_RST[`MCD_CTRL_CNT_HI:`MCD_CTRL_CNT_LO];
            message_interrupt_enable_q <= CTRL_RST[`MCD_CTRL_EN_BIT];
        end else if (we_ctrl) begin
            granted_message_count_q <= granted_message_count_d;
            message_interrupt_enable_q <= message_interrupt_enable_d;
        end
    end

    // ----------------------------------------
    // lower address
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            addr_lo_q <= `MCD_ZERO32;
        end else if (we_lo) begin
            addr_lo_q <= addr_lo_d;
        end
    end

    // ----------------------------------------
    // upper address
    // ----------------------------------------
    // a nonzero value switches the sender to 64-bit writes
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            addr_hi_q <= `MCD_ZERO32;
        end else if (we_hi) begin
            addr_hi_q <= addr_hi_d;
        end
    end

    // ----------------------------------------
    // payload
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            payload_q <= `MCD_ZERO16;
        end else if (we_pl) begin
            payload_q <= payload_d;
        end
    end

    // ----------------------------------------
    // read data register
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_q <= `MCD_ZERO32;
        end else if (cfg_rd) begin
            rdata_q <= rd_mux;
        end
    end

    assign cfg_rdata = rdata_q;
    assign cfg_hit = any_sel;

    // ----------------------------------------
    // message write
    // ----------------------------------------
    // the sender latches address and payload at launch
    mcd_msg_sender u_sender (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .enable(message_interrupt_enable_q),
        .event_pulse(irq_event),
        .addr_lo(addr_lo_q),
        .addr_hi(addr_hi_q),
        .payload({fixed_payload_bits, message_index_bits}),
        .wr_ready(wr_ready),
        .wr_valid(wr_valid),
        .wr_wide(wr_wide),
        .wr_addr(wr_addr),
        .wr_data(wr_data)
    );
endmodule : mcd_msi_cap

/* File: mcd_defs.svh */
// Purpose: offsets, field positions and reset values of the message interrupt capability
// Assumes: byte offsets in configuration space, registers reached by a 32-bit dword access
// Notes: definitions only
`ifndef MCD_DEFS_SVH
`define MCD_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define MCD_OFF_CTRL_DW 8'h70
`define MCD_OFF_ADDR_LO 8'h74
`define MCD_OFF_ADDR_HI 8'h78
`define MCD_OFF_PAYLOAD 8'h7c
`define MCD_OFF_CAPTAG_DW 8'h80

// ----------------------------------------
// field layout and constants
// ----------------------------------------
`define MCD_CTRL_RESET 16'h0080
`define MCD_CTRL_WIDE_BIT 7
`define MCD_CTRL_EN_BIT 0
`define MCD_CTRL_CNT_LO 4
`define MCD_CTRL_CNT_HI 6
`define MCD_CTRL_SHIFT 16
`define MCD_SUPPORTED_CNT 3'h0
`define MCD_CAP_TAG 8'h0d
`define MCD_ADDR_LO_MASK 32'hffff_fffc
`define MCD_ZERO32 32'h0000_0000
`define MCD_ZERO16 16'h0000
`define MCD_ZERO8 8'h00
`define MCD_ZERO24 24'h00_0000
`define MCD_PL_FIX_HI 15
`define MCD_PL_FIX_LO 4
`define MCD_PL_IDX_HI 3
`define MCD_PL_IDX_LO 0

`endif

/* File: mcd_pkg.sv */
// Purpose: shared types of the message interrupt capability
// Assumes: nothing
// Notes: constants live in mcd_defs.svh
package mcd_pkg;
    typedef enum logic [2:0] {
        MCD_IDLE = 3'b001,
        MCD_SEND = 3'b010,
        MCD_HOLD = 3'b100
    } mcd_state_type;
endpackage : mcd_pkg

/* File: mcd_msg_sender.sv */
// Purpose: issues one memory write per interrupt event
// Assumes: write channel handshakes with valid and ready
// Notes: events arriving while a write is pending are collected into one further write after it
`timescale 1ns/100ps
`include "mcd_defs.svh"

module mcd_msg_sender
    import mcd_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic event_pulse,
    input wire logic [31:0] addr_lo,
    input wire logic [31:0] addr_hi,
    input wire logic [15:0] payload,
    input wire logic wr_ready,
    output logic wr_valid,
    output logic wr_wide,
    output logic [63:0] wr_addr,
    output logic [31:0] wr_data
);
    mcd_state_type state_q, state_d;
    logic pend_q;
    logic [63:0] addr_q;
    logic [31:0] data_q;
    logic wide_q;
    wire logic wide_now = (addr_hi != `MCD_ZERO32);
    wire logic accept = (state_q == MCD_SEND) && wr_ready;

    // ----------------------------------------
    // state machine
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            MCD_IDLE: begin
                if (enable && (event_pulse || pend_q)) begin
                    state_d = MCD_SEND;
                end
            end
            MCD_SEND: begin
                if (accept) begin
                    state_d = MCD_HOLD;
                end
            end
            MCD_HOLD: begin
                state_d = MCD_IDLE;
            end
            default: state_d = MCD_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= MCD_IDLE;
            pend_q <= 1'b0;
            addr_q <= {`MCD_ZERO32, `MCD_ZERO32};
            data_q <= `MCD_ZERO32;
            wide_q <= 1'b0;
        end else begin
            state_q <= state_d;
            // an event during a send is kept for the next write
            if (event_pulse && state_q != MCD_IDLE) begin
                pend_q <= 1'b1;
            end else if (state_q == MCD_IDLE && state_d == MCD_SEND) begin
                pend_q <= 1'b0;
            end
            if (state_q == MCD_IDLE && state_d == MCD_SEND) begin
                wide_q <= wide_now;
                addr_q <= wide_now ? {addr_hi, addr_lo} : {`MCD_ZERO32, addr_lo};
                data_q <= {`MCD_ZERO16, payload};
            end
        end
    end

    assign wr_valid = (state_q == MCD_SEND);
    assign wr_wide = wide_q;
    assign wr_addr = addr_q;
    assign wr_data = data_q;
endmodule : mcd_msg_sender

/* File: mcd_msi_cap_asserts.sv */
// Purpose: port checks of mcd_msi_cap
// Assumes: one clock, sync reset
// Notes: bound after the module
`timescale 1ns/100ps
module mcd_msi_cap_asserts (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_hit,
    input wire logic wr_ready,
    input wire logic wr_valid,
    input wire logic wr_wide,
    input wire logic [63:0] wr_addr,
    input wire logic [31:0] wr_data
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_rd(a);
        cfg_rd && cfg_addr[7:2] == a;
    endsequence
    sequence s_take;
        wr_valid && wr_ready;
    endsequence
    a_ctrl_top: assert property (s_rd(6'h1c) |=> cfg_rdata[31:23] == 9'h001)
        else $error("control top bits wrong");
    a_ctrl_cap: assert property (s_rd(6'h1c) |=> cfg_rdata[19:17] == 3'h0)
        else $error("control count field wrong");
    a_tag_read: assert property (s_rd(6'h20) |=> cfg_rdata == 32'h0000_000d)
        else $error("tag wrong");
    a_addr_low: assert property (s_rd(6'h1d) |=> cfg_rdata[1:0] == 2'h0)
        else $error("address low bits set");
    a_miss_zero: assert property (cfg_rd && !cfg_hit |=> cfg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_req_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr))
        else $error("write request dropped");
    a_gap_after: assert property (s_take |=> !wr_valid)
        else $error("no gap after write");
    a_wide_match: assert property (wr_valid |-> wr_wide == (wr_addr[63:32] != 32'h0))
        else $error("width flag wrong");
    a_data_shape: assert property (wr_valid |-> wr_data[31:16] == 16'h0)
        else $error("data upper half set");
endmodule : mcd_msi_cap_asserts
bind mcd_msi_cap mcd_msi_cap_asserts i_chk (
    .core_clk, .sys_rst, .cfg_rd, .cfg_addr, .cfg_rdata, .cfg_hit,
    .wr_ready, .wr_valid, .wr_wide, .wr_addr, .wr_data
);

/* File: mcd_root_model.sv */
// Purpose: root side taking message writes
// Assumes: request holds until ready
// Notes: stall gives cycles before ready
`timescale 1ns/100ps
module mcd_root_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic wr_valid,
    input wire logic [3:0] stall,
    output logic wr_ready
);
    logic [3:0] wait_q;
    assign wr_ready = wr_valid && (wait_q >= stall);
    always_ff @(posedge core_clk) begin
        if (sys_rst || !wr_valid || wr_ready) begin
            wait_q <= 4'h0;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule : mcd_root_model

/* File: testbench.sv */
// Purpose: register and message tests of mcd_msi_cap
// Assumes: inputs change on the falling edge
// Notes: root side stalls by a varying count
`timescale 1ns/100ps
module testbench;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cfg_wr = 1'b0, cfg_rd = 1'b0, irq_event = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [3:0] cfg_be = 4'h0, stall = 4'h0;
    logic [31:0] cfg_wdata = 32'h0, cfg_rdata, wr_data;
    logic cfg_hit, wr_ready, wr_valid, wr_wide;
    logic [63:0] wr_addr;
    int failures = 0, cmp_count = 0;
    always #50 core_clk = ~core_clk;
    mcd_msi_cap i_mcd_msi_cap (.core_clk, .sys_rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be,
        .cfg_wdata, .cfg_rdata, .cfg_hit, .irq_event, .wr_ready, .wr_valid, .wr_wide,
        .wr_addr, .wr_data);
    mcd_root_model i_mcd_root_model (.core_clk, .sys_rst, .wr_valid, .stall, .wr_ready);
    task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s exp %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge core_clk);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        @(negedge core_clk);
        cfg_wr = 1'b0;
        cfg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic hit;
        // mapped dwords: 70h, 74h, 78h, 7ch and 80h
        hit = (a[7:2] inside {6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h20});
        @(negedge core_clk);
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(negedge core_clk);
        cfg_rd = 1'b0;
        chk("rdata", {32'h0, cfg_rdata}, {32'h0, exp});
        chk("cfg_hit", {63'h0, cfg_hit}, {63'h0, hit});
    endtask : rd
    task automatic send(input int exp_n, input bit twice, input logic [63:0] ea,
                        input logic [31:0] ed);
        int n;
        n = 0;
        @(negedge core_clk);
        irq_event = 1'b1;
        for (int i = 0; i < 20; i++) begin
            @(negedge core_clk);
            // a second event while the first write is still pending
            irq_event = twice && (i == 2);
            if ((wr_valid && wr_ready) === 1'b1) begin
                n++;
                chk("wr_addr", wr_addr, ea);
                chk("wr_data", {32'h0, wr_data}, {32'h0, ed});
                chk("wr_wide", {63'h0, wr_wide}, {63'h0, ea[63:32] != 32'h0});
            end
        end
        chk("writes", 64'(n), 64'(exp_n));
    endtask : send
    task automatic conclude;
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude
    initial begin
        #(100 * 3000);
        failures++;
        conclude();
    end
    initial begin
        repeat (8) @(negedge core_clk);
        sys_rst = 1'b0;
        rd(8'h72, 32'h0080_0000);
        rd(8'h78, 32'h0);
        rd(8'h7c, 32'h0);
        rd(8'h80, 32'h0000_000d);
        rd(8'h90, 32'h0);
        $display("test reset values done");
        wr(8'h70, 4'hf, 32'hffff_ffff);
        rd(8'h70, 32'h00f1_0000);
        wr(8'h74, 4'hf, 32'hffff_ffff);
        rd(8'h74, 32'hffff_fffc);
        wr(8'h80, 4'hf, 32'hffff_ffff);
        rd(8'h80, 32'h0000_000d);
        wr(8'h78, 4'hf, 32'hffff_ffff);
        rd(8'h78, 32'hffff_ffff);
        $display("test access kinds done");
        wr(8'h70, 4'hc, 32'h0);
        wr(8'h74, 4'hf, 32'h1234_5679);
        wr(8'h78, 4'hf, 32'h0);
        wr(8'h7c, 4'hf, 32'h0000_abc5);
        send(0, 1'b0, 64'h0, 32'h0);
        for (int c = 0; c < 6; c++) begin
            stall = 4'(c);
            wr(8'h70, 4'hc, {9'h0, 3'(c), 4'h1, 16'h0});
            rd(8'h70, {9'h001, 3'(c), 4'h1, 16'h0});
            send(1, 1'b0, 64'h1234_5678, 32'h0000_abc5);
        end
        wr(8'h78, 4'hf, 32'h0000_0001);
        send(1, 1'b0, 64'h0000_0001_1234_5678, 32'h0000_abc5);
        send(2, 1'b1, 64'h0000_0001_1234_5678, 32'h0000_abc5);
        $display("test messages done");
        // a reset in mid-run returns every register to its reset value
        @(negedge core_clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        rd(8'h72, 32'h0080_0000);
        rd(8'h74, 32'h0);
        rd(8'h78, 32'h0);
        send(0, 1'b0, 64'h0, 32'h0);
        $display("test mid reset done");
        conclude();
    end
endmodule : testbench
